//--- core/pws_pkg.sv
// Constants and types shared by the power-up and wake sequencer.
package pws_pkg;
  localparam int CLK_MHZ = 100;
  // Crystal start-up time in microseconds; not given, plain default.
  localparam int XTAL_START_US = 1;
  localparam int XTAL_START_CYC = XTAL_START_US * CLK_MHZ;
  // Supply ramp gap between regulated/digital supply and reset release.
  localparam int SUPPLY_GAP_NS = 100;
  localparam int SUPPLY_GAP_CYC = (SUPPLY_GAP_NS * CLK_MHZ + 999) / 1000;
  // PLL lock is nominally 5 us; this is a timeout guard only.
  localparam int PLL_LOCK_US = 5;
  localparam int PLL_LOCK_CYC = PLL_LOCK_US * CLK_MHZ;
  // Longest init-to-idle on wake, 40 us, rounded down.
  localparam int WAKE_INIT_MAX_US = 40;
  localparam int WAKE_INIT_MAX_CYC = WAKE_INIT_MAX_US * CLK_MHZ;
  localparam int CFG_WORDS = 16;
  localparam int CFG_ADDR_W = 4;
  localparam int CFG_DATA_W = 32;
  localparam int CNT_W = 13;
  localparam logic [1:0] SPI_MODE_RESET = 2'h0;
  typedef enum logic [2:0] {
    PWS_OFF = 3'b000,
    PWS_XTAL = 3'b001,
    PWS_SUPPLY = 3'b010,
    PWS_INIT = 3'b011,
    PWS_IDLE = 3'b100,
    PWS_SLEEP = 3'b101
  } pws_state_type;
endpackage

//--- core/pws_retained_array.sv
// Retained configuration array on the always-on supply.
`timescale 1ns/100ps
`default_nettype none
module pws_retained_array (
  input wire logic clk,
  input wire logic retention_supply,
  input wire logic wr_en,
  input wire logic [pws_pkg::CFG_ADDR_W-1:0] wr_addr,
  input wire logic [pws_pkg::CFG_DATA_W-1:0] wr_data,
  input wire logic [pws_pkg::CFG_ADDR_W-1:0] rd_addr,
  output logic [pws_pkg::CFG_DATA_W-1:0] rd_data
);
  import pws_pkg::*;
  logic [CFG_DATA_W-1:0] mem [CFG_WORDS];
  logic [CFG_DATA_W-1:0] next_rd_data;

  // Contents survive any reset; reads return zero while the retention supply is off.
  always_comb begin
    next_rd_data = retention_supply ? mem[rd_addr] : '0;
  end

  always_ff @(posedge clk) begin
    if (wr_en && retention_supply) begin
      mem[wr_addr] <= wr_data; // R7
    end
    rd_data <= next_rd_data;
  end
endmodule // pws_retained_array
`default_nettype wire

//--- core/pws_sequencer.sv
// Power-up and wake sequencer of the transceiver.
// Function
// (R1) Drive external-on high once supply valid
// (R2) Crystal start, usable after start-up time
// (R3) Raise supplies before releasing reset line
// (R4) Reset line rise marks init state
// (R5) Wake reloads retained config, within 40us
// (R6) Cold power-up idles on PLL lock
// (R7) Retained array keeps config while powered
// (R8) Host fast serial only in idle
// (R9) Host uses slow clock for designated accesses
// (R10) Latch serial mode pins at reset rise
// (R11) Host waits init-to-idle before access
`timescale 1ns/100ps
`default_nettype none
module pws_sequencer (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic supply_ok,
  input wire logic retention_supply,
  input wire logic xtal_running,
  input wire logic pll_lock,
  input wire logic sleep_req,
  input wire logic wake_req,
  input wire logic [1:0] spi_mode_pins,
  input wire logic cfg_save_en,
  input wire logic [pws_pkg::CFG_ADDR_W-1:0] cfg_save_addr,
  input wire logic [pws_pkg::CFG_DATA_W-1:0] cfg_save_data,
  output logic external_on_output,
  output logic xtal_enable,
  output logic regulated_supply_output,
  output logic digital_core_supply,
  output logic reset_line,
  output logic device_idle,
  output logic deep_sleep_state,
  output logic init_timeout,
  output logic [1:0] spi_mode,
  output logic cfg_load_en,
  output logic [pws_pkg::CFG_ADDR_W-1:0] cfg_load_addr,
  output logic [pws_pkg::CFG_DATA_W-1:0] cfg_load_data
);
  import pws_pkg::*;

  pws_state_type state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic waking, next_waking;
  logic [CFG_ADDR_W-1:0] rd_ptr, next_rd_ptr;
  logic rd_valid, next_rd_valid;
  logic rd_last, next_rd_last;
  logic load_done, next_load_done;
  logic [CFG_ADDR_W-1:0] load_addr_q, next_load_addr_q;
  logic reset_line_q, next_reset_line_q;
  logic [1:0] spi_mode_q, next_spi_mode_q;
  logic timeout_q, next_timeout_q;
  logic [CFG_DATA_W-1:0] array_rd;

  pws_retained_array u_array (
    .clk(clk),
    .retention_supply(retention_supply),
    .wr_en(cfg_save_en && (state == PWS_IDLE)),
    .wr_addr(cfg_save_addr),
    .wr_data(cfg_save_data),
    .rd_addr(rd_ptr),
    .rd_data(array_rd)
  );

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_waking = waking;
    next_rd_ptr = rd_ptr;
    next_rd_valid = 1'b0;
    next_rd_last = 1'b0;
    next_load_done = load_done;
    next_load_addr_q = load_addr_q;
    next_timeout_q = timeout_q;
    case (state)
      PWS_OFF: begin
        next_cnt = '0;
        next_waking = 1'b0;
        if (supply_ok) begin
          next_state = PWS_XTAL; // R1
        end
      end
      PWS_XTAL: begin
        // Crystal counted as usable only after a full start-up interval.
        if (!xtal_running) begin
          next_cnt = '0;
        end else if (cnt >= CNT_W'(XTAL_START_CYC - 1)) begin
          next_cnt = '0;
          next_state = PWS_SUPPLY; // R2
        end else begin
          next_cnt = cnt + 1'b1;
        end
      end
      PWS_SUPPLY: begin
        if (cnt >= CNT_W'(SUPPLY_GAP_CYC - 1)) begin
          next_cnt = '0;
          next_state = PWS_INIT; // R3
          next_rd_ptr = '0;
          next_load_done = 1'b0;
          next_timeout_q = 1'b0;
        end else begin
          next_cnt = cnt + 1'b1;
        end
      end
      PWS_INIT: begin
        next_cnt = cnt + 1'b1;
        if (waking) begin
          // Stream the array out one word a cycle into the registers.
          if (!load_done && !rd_last) begin
            next_rd_valid = 1'b1;
            next_load_addr_q = rd_ptr;
            next_rd_last = (rd_ptr == CFG_ADDR_W'(CFG_WORDS - 1));
            next_rd_ptr = rd_ptr + 1'b1;
          end
          if (rd_last) begin
            next_load_done = 1'b1;
          end
          if (load_done) begin
            next_state = PWS_IDLE; // R5
          end
          if (cnt >= CNT_W'(WAKE_INIT_MAX_CYC - 1)) begin
            next_timeout_q = 1'b1;
          end
        end else begin
          if (pll_lock) begin
            next_state = PWS_IDLE; // R6
          end
          if (cnt >= CNT_W'(PLL_LOCK_CYC * 2 - 1)) begin
            next_timeout_q = 1'b1;
          end
        end
      end
      PWS_IDLE: begin
        next_cnt = '0;
        if (sleep_req) begin
          next_state = PWS_SLEEP;
        end
      end
      PWS_SLEEP: begin
        // Without the retention supply there is nothing to reload.
        if (!retention_supply) begin
          next_state = PWS_OFF;
        end else if (wake_req) begin
          next_waking = 1'b1;
          next_cnt = '0;
          next_state = PWS_XTAL;
        end
      end
      default: begin
        next_state = PWS_OFF;
      end
    endcase
    if (!supply_ok) begin
      next_state = PWS_OFF;
    end
    next_reset_line_q = (next_state == PWS_INIT) ||
                        (next_state == PWS_IDLE); // R4
    next_spi_mode_q = spi_mode_q;
    if (next_reset_line_q && !reset_line_q) begin
      next_spi_mode_q = spi_mode_pins; // R10
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state <= PWS_OFF;
      cnt <= '0;
      waking <= 1'b0;
      rd_ptr <= '0;
      rd_valid <= 1'b0;
      rd_last <= 1'b0;
      load_done <= 1'b0;
      load_addr_q <= '0;
      reset_line_q <= 1'b0;
      spi_mode_q <= SPI_MODE_RESET;
      timeout_q <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      waking <= next_waking;
      rd_ptr <= next_rd_ptr;
      rd_valid <= next_rd_valid;
      rd_last <= next_rd_last;
      load_done <= next_load_done;
      load_addr_q <= next_load_addr_q;
      reset_line_q <= next_reset_line_q;
      spi_mode_q <= next_spi_mode_q;
      timeout_q <= next_timeout_q;
    end
  end

  always_comb begin
    external_on_output = (state != PWS_OFF) && (state != PWS_SLEEP); // R1
    xtal_enable = external_on_output; // R2
    regulated_supply_output = (state == PWS_SUPPLY) || reset_line_q; // R3
    digital_core_supply = regulated_supply_output; // R3
    reset_line = reset_line_q;
    device_idle = (state == PWS_IDLE); // R8
    deep_sleep_state = (state == PWS_SLEEP);
    init_timeout = timeout_q;
    spi_mode = spi_mode_q;
    cfg_load_en = rd_valid; // R5
    cfg_load_addr = load_addr_q;
    cfg_load_data = array_rd;
  end
endmodule // pws_sequencer
`default_nettype wire

//--- dv/pws_props.sv
// Concurrent checks on the sequencer ports.
`timescale 1ns/100ps
`default_nettype none
module pws_props (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic supply_ok,
  input wire logic external_on_output,
  input wire logic xtal_enable,
  input wire logic regulated_supply_output,
  input wire logic digital_core_supply,
  input wire logic reset_line,
  input wire logic device_idle,
  input wire logic deep_sleep_state,
  input wire logic [1:0] spi_mode,
  input wire logic cfg_load_en,
  input wire logic [pws_pkg::CFG_ADDR_W-1:0] cfg_load_addr
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Counts cycles spent out of reset but not yet idle. It saturates so a
  // hung init keeps the check failing rather than wrapping back to legal.
  logic [12:0] init_cyc;
  always_ff @(posedge clk) begin
    if (!rst_b || !reset_line || device_idle) begin
      init_cyc <= 13'h0000;
    end else if (init_cyc != 13'h1fff) begin
      init_cyc <= init_cyc + 13'h0001;
    end
  end
  sequence rst_rise;
    $rose(reset_line);
  endsequence
  chk_on_needs_supply: assert property ($rose(external_on_output) |-> $past(supply_ok))
    else $error("external-on rose without supply");
  chk_off_on_drop: assert property (!supply_ok |=> !external_on_output && !reset_line)
    else $error("outputs stay up after supply drop");
  chk_xtal_with_on: assert property (external_on_output |-> xtal_enable)
    else $error("crystal not enabled with external-on");
  chk_supply_before_rst: assert property (rst_rise |-> $past(regulated_supply_output, 5) && $past(digital_core_supply, 5))
    else $error("reset released before supplies");
  chk_idle_in_init: assert property (device_idle |-> reset_line && regulated_supply_output)
    else $error("idle without reset released");
  chk_init_bound: assert property (init_cyc < 13'h0fa0)
    else $error("init did not reach idle in time");
  chk_load_start: assert property ($rose(cfg_load_en) |-> cfg_load_addr == 4'h0 && !device_idle)
    else $error("reload did not start at word zero in init");
  chk_sleep_quiet: assert property (deep_sleep_state |-> !device_idle && !reset_line)
    else $error("sleep with device active");
  chk_mode_held: assert property (reset_line [*3] |-> $stable(spi_mode))
    else $error("serial mode changed while out of reset");
endmodule // pws_props
`default_nettype wire

//--- dv/pws_host_model.sv
// Host model that stores retained words once the device is idle.
`timescale 1ns/100ps
`default_nettype none
module pws_host_model (
  input wire logic clk,
  input wire logic host_go,
  input wire logic device_idle,
  input wire logic reset_line,
  output logic cfg_save_en,
  output logic [pws_pkg::CFG_ADDR_W-1:0] cfg_save_addr,
  output logic [pws_pkg::CFG_DATA_W-1:0] cfg_save_data
);
  import pws_pkg::*;
  logic [31:0] pattern;
  initial cfg_save_en = 1'b0;
  initial cfg_save_addr = 4'h0;
  // Accesses start only once reset has risen and the device idles.
  always @(negedge clk) begin
    cfg_save_en <= host_go && device_idle && reset_line;
    if (cfg_save_en) cfg_save_addr <= cfg_save_addr + 4'h1;
  end
  assign pattern = {16'hc0de, 12'h000, cfg_save_addr};
  // Idle data is scrambled so a stale word never looks valid.
  assign cfg_save_data = cfg_save_en ? pattern : ~pattern;
endmodule // pws_host_model
`default_nettype wire

//--- dv/pws_sequencer_tb.sv
// Self-checking bench for the power-up and wake sequencer.
`timescale 1ns/100ps
`default_nettype none
module pws_sequencer_tb;
  import pws_pkg::*;
  logic clk = 1'b0, rst_b = 1'b0, supply_ok = 1'b0, retention_supply = 1'b1;
  logic xtal_running = 1'b0, pll_lock = 1'b0, sleep_req = 1'b0;
  logic wake_req = 1'b0, host_go = 1'b0;
  logic [1:0] spi_mode_pins = 2'h0;
  logic cfg_save_en, external_on_output, xtal_enable, regulated_supply_output;
  logic digital_core_supply, reset_line, device_idle, deep_sleep_state;
  logic init_timeout, cfg_load_en;
  logic [1:0] spi_mode;
  logic [3:0] cfg_save_addr, cfg_load_addr;
  logic [31:0] cfg_save_data, cfg_load_data;
  int mismatches = 0, checked = 0;
  pws_sequencer DUT (.*);
  pws_host_model host (.*);
  initial forever #5 clk = ~clk;
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic final_report();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cycles(int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic cold_up();
    spi_mode_pins = 2'h2;
    supply_ok = 1'b1;
    xtal_running = 1'b1;
    cycles(1);
    check("external_on", 1, external_on_output);
    check("xtal_enable", 1, xtal_enable);
    check("early supply", 0, regulated_supply_output);
    cycles(XTAL_START_CYC);
    check("supply", 1, regulated_supply_output & digital_core_supply);
    check("early reset", 0, reset_line);
    cycles(10);
    check("reset_line", 1, reset_line);
    cycles(1);
    spi_mode_pins = 2'h0;
    pll_lock = 1'b1;
    cycles(1);
    check("spi_mode", 2, spi_mode);
    check("cold idle", 1, device_idle);
    check("cold timeout", 0, init_timeout);
  endtask
  task automatic sleep_wake();
    int n;
    n = 0;
    host_go = 1'b1;
    cycles(20);
    host_go = 1'b0;
    sleep_req = 1'b1;
    cycles(2);
    sleep_req = 1'b0;
    check("sleep", 1, deep_sleep_state);
    check("sleep reset", 0, reset_line);
    wake_req = 1'b1;
    cycles(1);
    wake_req = 1'b0;
    for (int i = 0; i < 1000 && device_idle !== 1'b1; i++) begin
      cycles(1);
      if (cfg_load_en === 1'b1) begin
        check("load addr", n, cfg_load_addr);
        check("load data", {16'hc0de, 12'h000, n[3:0]}, cfg_load_data);
        n++;
      end
    end
    if (device_idle !== 1'b1) begin
      mismatches++;
      final_report();
    end
    check("load count", 16, n);
    check("wake spi_mode", 0, spi_mode);
    check("wake timeout", 0, init_timeout);
  endtask
  task automatic supply_drop();
    supply_ok = 1'b0;
    cycles(2);
    check("drop on", 0, external_on_output);
    check("drop reset", 0, reset_line);
  endtask
  initial begin
    cycles(20);
    rst_b = 1'b1;
    cold_up();
    sleep_wake();
    supply_drop();
    final_report();
  end
endmodule // pws_sequencer_tb
bind pws_sequencer pws_props u_props (.*);
`default_nettype wire
